// ### hw/windowed_watchdog_timer.sv
// windowed watchdog_unit with apb registers, key clear and interrupt
// assumes count strobes come from the clock generator, synchronous to pclk
// assumes the chip reset requested by wdt_reset returns through presetn
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "wdt_map.svh"
module windowed_watchdog_timer #(
  parameter int CNT_W = 16,  // counter width
  parameter int P0    = 7,   // log2 ticks, period select 0
  parameter int P1    = 9,   // log2 ticks, period select 1
  parameter int P2    = 11,  // log2 ticks, period select 2
  parameter int P3    = 13   // log2 ticks, period select 3
) (
  input  wire logic        pclk,      // apb clock, 125 MHz
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb enable
  input  wire logic        pwrite,    // apb direction
  input  wire logic [11:0] paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error, unmapped
  input  wire logic        rc_tick,   // dedicated rc kilohertz strobe
  input  wire logic        ls_tick,   // low-speed clock strobe
  input  wire logic [1:0]  cpu_level, // cpu_exception_level
  input  wire logic        stop_mode, // stop or deep-stop mode
  output logic             irq,       // level interrupt
  output logic             wdt_reset, // reset request, held
  output logic             invalid_clear // reset cause: bad clear
);
  import wdt_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  apb_req_t              req;
  mode_t                 mode;
  logic [CNT_W-1:0]      count;
  logic [CNT_W-1:0]      limit;
  logic [CNT_W-1:0]      win_start;
  logic                  pend_a;
  logic                  pend_b;
  logic                  ovf_seen;
  logic [`EVT_W-1:0]     evt_status;
  logic [`EVT_W-1:0]     evt_mask;
  logic [`EVT_W-1:0]     evt_set;
  logic                  tick;
  logic                  key_ok;
  logic                  ignored;
  logic                  access;
  logic                  wr_done;
  logic                  mapped;
  logic                  overflow;
  logic                  windowed;
  logic                  in_window;
  logic [31:0]           next_rdata;
  // decoded selects, write strobes and reset causes
  logic                  sel_clear;
  logic                  sel_mode;
  logic                  sel_status;
  logic                  sel_evt_status;
  logic                  sel_evt_mask;
  logic                  sel_count;
  logic                  wr_clear;
  logic                  wr_mode;
  logic                  wr_evt_status;
  logic                  wr_evt_mask;
  logic                  clear_tick;
  logic                  timeout_hit;
  logic                  window_fault;

  // bundle the request so decode and writes read one carrier
  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

  // ----------------------------------------
  // apb handshake
  // ----------------------------------------
  // one wait state so that every answer comes from a flop
  assign access  = psel & penable;
  assign wr_done = access & pready & req.write;

  // address decode; offsets off the map, misaligned ones too, are unmapped
  always_comb begin
    sel_clear      = 1'b0;
    sel_mode       = 1'b0;
    sel_status     = 1'b0;
    sel_evt_status = 1'b0;
    sel_evt_mask   = 1'b0;
    sel_count      = 1'b0;
    mapped         = 1'b1;
    if (req.addr == `OFS_CLEAR) begin
      sel_clear = 1'b1;
    end else if (req.addr == `OFS_MODE) begin
      sel_mode = 1'b1;
    end else if (req.addr == `OFS_STATUS) begin
      sel_status = 1'b1;
    end else if (req.addr == `OFS_EVT_STATUS) begin
      sel_evt_status = 1'b1;
    end else if (req.addr == `OFS_EVT_MASK) begin
      sel_evt_mask = 1'b1;
    end else if (req.addr == `OFS_COUNT) begin
      sel_count = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  // read mux; the clear register is write-only and reads as zero
  always_comb begin
    next_rdata = 32'h0;
    if (sel_mode) begin
      next_rdata = {{(32-`MODE_W){1'b0}}, mode};
    end else if (sel_status) begin
      next_rdata = {29'h0, ovf_seen, pend_b, pend_a};
    end else if (sel_evt_status) begin
      next_rdata = {{(32-`EVT_W){1'b0}}, evt_status};
    end else if (sel_evt_mask) begin
      next_rdata = {{(32-`EVT_W){1'b0}}, evt_mask};
    end else if (sel_count) begin
      next_rdata = {{(32-CNT_W){1'b0}}, count};
    end
  end

  // write strobes fire at the edge where pready is sampled high
  assign wr_clear      = wr_done & sel_clear;
  assign wr_mode       = wr_done & sel_mode;
  assign wr_evt_status = wr_done & sel_evt_status;
  assign wr_evt_mask   = wr_done & sel_evt_mask;

  // answer registered on the first access cycle; one wait state, never more
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // error only for offsets outside the map; such a write is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & ~mapped;
    end
  end

  // read data holds until the next read, so a late sampler still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (access && !pready && !req.write) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // mode and mask registers
  // ----------------------------------------
  // mode writes are not blocked; software must wait for clear flags first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= `MODE_RESET;
    end else if (wr_mode) begin
      mode <= req.wdata[`MODE_W-1:0];
    end
  end

  // mask shares the event status layout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= '0;
    end else if (wr_evt_mask) begin
      evt_mask <= req.wdata[`EVT_W-1:0];
    end
  end

  // ----------------------------------------
  // clear key and count strobe
  // ----------------------------------------
  // key and level gate
  wdt_key_detect u_key (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_stb  (wr_clear),
    .wbyte   (req.wdata[7:0]),
    .level   (cpu_level),
    .key_ok  (key_ok),
    .ignored (ignored)
  );

  wdt_tick_select u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .rc_tick   (rc_tick),
    .ls_tick   (ls_tick),
    .clock_sel (mode.clock_sel),
    .stop_mode (stop_mode),
    .tick      (tick)
  );

  // ----------------------------------------
  // period and window
  // ----------------------------------------
  // long periods are only accurate on the low-speed source; not enforced
  always_comb begin
    case (mode.period)
      2'h0:    limit = CNT_W'((1 << P0) - 1);
      2'h1:    limit = CNT_W'((1 << P1) - 1);
      2'h2:    limit = CNT_W'((1 << P2) - 1);
      default: limit = CNT_W'((1 << P3) - 1);
    endcase
  end

  // window opens after the first quarter or first half of the period
  always_comb begin
    case (mode.window)
      win_75:  win_start = CNT_W'((limit >> 2) + 1'b1);
      win_50:  win_start = CNT_W'((limit >> 1) + 1'b1);
      default: win_start = '0;
    endcase
  end

  // the reserved window code behaves as the full window
  assign windowed  = (mode.window == win_75) || (mode.window == win_50);
  assign in_window = count >= win_start;
  // a tick that applies a pending clear restarts the count, so it cannot overflow
  assign clear_tick = tick & pend_a;
  assign overflow  = tick & ~pend_a & (count == limit) & ~wdt_reset;

  // ----------------------------------------
  // clear pending flags
  // ----------------------------------------
  // clear within two ticks
  // flag a covers key to counter clear; a new key while waiting keeps it set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_a <= 1'b0;
    end else if (key_ok) begin
      pend_a <= 1'b1;
    end else if (clear_tick) begin
      pend_a <= 1'b0;
    end
  end

  // flag b covers the tick after the clear, so software sees the whole span
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_b <= 1'b0;
    end else if (clear_tick) begin
      pend_b <= 1'b1;
    end else if (tick) begin
      pend_b <= 1'b0;
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // counts only on qualified strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clear_tick) begin
      count <= '0;
    end else if (overflow) begin
      count <= '0;
    end else if (tick && !wdt_reset) begin
      count <= count + 1'b1;
    end
  end

  // first overflow remembered
  // only an applied clear forgets it; reading the status does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_seen <= 1'b0;
    end else if (overflow && !windowed) begin
      ovf_seen <= 1'b1;
    end else if (clear_tick) begin
      ovf_seen <= 1'b0;
    end
  end

  // ----------------------------------------
  // reset request
  // ----------------------------------------
  // windowed overflow resets
  assign timeout_hit  = overflow & (windowed | ovf_seen);
  assign window_fault = key_ok & windowed & ~in_window;

  // held until the chip reset returns through presetn; the count stops advancing meanwhile, but a pending clear still zeroes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reset <= 1'b0;
    end else if (timeout_hit || window_fault) begin
      wdt_reset <= 1'b1;
    end
  end

  // cause bit tells a bad clear from a timeout until the chip reset clears it through presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      invalid_clear <= 1'b0;
    end else if (window_fault) begin
      invalid_clear <= 1'b1;
    end
  end

  // ----------------------------------------
  // events and interrupt
  // ----------------------------------------
  // no overflow interrupt when windowed
  assign evt_set[`EVT_OVERFLOW] = overflow & ~windowed & ~ovf_seen;
  assign evt_set[`EVT_CLEARED]  = clear_tick;
  assign evt_set[`EVT_IGNORED]  = ignored;

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= '0;
    end else if (wr_evt_status) begin
      evt_status <= (evt_status & ~req.wdata[`EVT_W-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  // level interrupt, one cycle behind the status, straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_status & evt_mask);
    end
  end

endmodule : windowed_watchdog_timer

// ### hw/wdt_map.svh
// register map, field positions, reset values and key bytes of the watchdog_unit
// assumes inclusion by bare name from every file that decodes registers
// Function
// - key 0x5A then 0xA5 clears counter
// - clears ignored at exception level two up
// - only levels zero and one may clear
// - windowed mode: no overflow interrupt, overflow resets
// - windowed clear outside window resets
// - counter halts in stop and deep-stop
// - count clock selectable rc or low-speed
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CLEAR      12'h000
`define OFS_MODE       12'h004
`define OFS_STATUS     12'h008
`define OFS_EVT_STATUS 12'h00c
`define OFS_EVT_MASK   12'h010
`define OFS_COUNT      12'h014

// ----------------------------------------
// key bytes and fields
// ----------------------------------------
`define KEY_FIRST      8'h5a
`define KEY_SECOND     8'ha5
`define MODE_W         5
`define MODE_RESET     5'h00
`define EVT_W          3
`define EVT_OVERFLOW   0
`define EVT_CLEARED    1
`define EVT_IGNORED    2
`define LEVEL_NO_CLEAR 2'h2

`endif

// ### hw/wdt_pkg.sv
// types shared by the watchdog_unit files
// assumes wdt_map.svh supplies all numeric constants
package wdt_pkg;

  // ----------------------------------------
  // mode register layout
  // ----------------------------------------
  typedef enum logic [1:0] {
    win_full,
    win_75,
    win_50,
    win_rsvd
  } window_t;

  typedef struct packed {
    logic    clock_sel;  // 0 dedicated rc, 1 low-speed
    window_t window;
    logic [1:0] period;  // overflow period select
  } mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
  } apb_req_t;

  typedef enum logic {
    key_idle,
    key_armed
  } key_state_t;

endpackage : wdt_pkg

// ### hw/wdt_tick_select.sv
// picks the watchdog_count_clock strobe and halts it in stop modes
// assumes both tick inputs are one-cycle strobes synchronous to pclk
`timescale 1ns/100ps
module wdt_tick_select (
  input  wire logic pclk,      // system clock
  input  wire logic presetn,   // async reset, active low
  input  wire logic rc_tick,   // dedicated rc kilohertz strobe
  input  wire logic ls_tick,   // low-speed clock strobe
  input  wire logic clock_sel, // 1 picks low-speed
  input  wire logic stop_mode, // stop or deep-stop active
  output logic      tick       // qualified count strobe
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= (clock_sel ? ls_tick : rc_tick) & ~stop_mode;
    end
  end

endmodule : wdt_tick_select

// ### hw/wdt_key_detect.sv
// two-byte clear key detector on the counter_clear_register
// assumes wr_stb pulses once per completed write to that register
`timescale 1ns/100ps
`include "wdt_map.svh"
module wdt_key_detect (
  input  wire logic       pclk,    // system clock
  input  wire logic       presetn, // async reset, active low
  input  wire logic       wr_stb,  // clear register write
  input  wire logic [7:0] wbyte,   // written byte
  input  wire logic [1:0] level,   // cpu_exception_level
  output logic            key_ok,  // full key seen, one cycle
  output logic            ignored  // write dropped for level
);
  import wdt_pkg::*;

  key_state_t state;
  logic       allowed;

  assign allowed = level < `LEVEL_NO_CLEAR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= key_idle;
      key_ok  <= 1'b0;
      ignored <= 1'b0;
    end else begin
      key_ok  <= 1'b0;
      ignored <= wr_stb & ~allowed;
      if (wr_stb && allowed) begin
        case (state)
          key_idle: begin
            if (wbyte == `KEY_FIRST) state <= key_armed;
          end
          default: begin
            state  <= key_idle;
            key_ok <= (wbyte == `KEY_SECOND);
            if (wbyte == `KEY_FIRST) state <= key_armed;
          end
        endcase
      end
    end
  end

endmodule : wdt_key_detect

// ### verif/wdt_checker_sva.sv
// checker on the watchdog ports: bus answer, reset causes, key timing
// assumes binding to windowed_watchdog_timer, one clock domain
`timescale 1ns/100ps
`include "wdt_map.svh"
module wdt_checker_sva (
  input wire logic        pclk,         // clock
  input wire logic        presetn,      // reset, low
  input wire logic        psel,         // select
  input wire logic        penable,      // enable
  input wire logic        pwrite,       // direction
  input wire logic [11:0] paddr,        // address
  input wire logic [31:0] pwdata,       // write data
  input wire logic        pready,       // ready
  input wire logic        pslverr,      // error
  input wire logic        rc_tick,      // rc strobe
  input wire logic        ls_tick,      // low-speed strobe
  input wire logic [1:0]  cpu_level,    // exception level
  input wire logic        stop_mode,    // stop modes
  input wire logic        irq,          // interrupt
  input wire logic        wdt_reset,    // reset request
  input wire logic        invalid_clear // bad clear cause
);
  logic [2:0] key_hist; // accepted second key bytes, newest in bit 0

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------
  // helper
  // ----------------
  // a window fault can only follow a completed key at a clearing level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_hist <= 3'h0;
    end else begin
      key_hist <= {key_hist[1:0], psel && penable && pready && pwrite &&
                   paddr == `OFS_CLEAR && pwdata[7:0] == `KEY_SECOND &&
                   cpu_level < `LEVEL_NO_CLEAR};
    end
  end

  // ----------------
  // properties
  // ----------------
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_one_wait: assert property (s_taken |=> s_answer)
    else $error("pready not one cycle after access");
  a_ready_needs_req: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > `OFS_COUNT || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address");
  a_reset_sticky: assert property (wdt_reset |=> wdt_reset)
    else $error("reset request dropped");
  a_invalid_has_reset: assert property (invalid_clear |-> wdt_reset)
    else $error("bad clear cause without reset");
  a_invalid_after_key: assert property ($rose(invalid_clear) |-> key_hist != 3'h0)
    else $error("bad clear cause without key");
  a_reset_cause_tick: assert property ($rose(wdt_reset) |-> invalid_clear ||
    $past(rc_tick || ls_tick, 2) || $past(rc_tick || ls_tick, 3) ||
    $past(rc_tick || ls_tick, 4))
    else $error("reset request without count strobe");
  a_stop_no_timeout: assert property (stop_mode [*4] |-> !$rose(wdt_reset) || invalid_clear)
    else $error("timeout while stopped");
  a_quiet_after_reset: assert property ($rose(presetn) |-> !irq && !wdt_reset && !invalid_clear)
    else $error("outputs not idle after reset");
endmodule : wdt_checker_sva

bind windowed_watchdog_timer wdt_checker_sva u_wdt_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rc_tick(rc_tick), .ls_tick(ls_tick), .cpu_level(cpu_level), .stop_mode(stop_mode),
  .irq(irq), .wdt_reset(wdt_reset), .invalid_clear(invalid_clear)
);

// ### verif/windowed_watchdog_timer_tb.sv
// self-checking bench for the windowed watchdog over apb
// assumes short periods (8 ticks at select 0); strobes are one pclk wide
`timescale 1ns/100ps
`include "wdt_map.svh"
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        rc_tick = 1'b0, ls_tick = 1'b0, stop_mode = 1'b0;
  logic [1:0]  cpu_level = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic        pready, pslverr, irq, wdt_reset, invalid_clear, err;
  int          mismatches = 0, comparisons = 0;

  windowed_watchdog_timer #(.P0(3), .P1(4), .P2(5), .P3(6)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_tick(rc_tick), .ls_tick(ls_tick), .cpu_level(cpu_level), .stop_mode(stop_mode),
    .irq(irq), .wdt_reset(wdt_reset), .invalid_clear(invalid_clear));

  // 125 MHz
  always #4 pclk = ~pclk;

  // ----------------
  // tasks
  // ----------------
  task stop_test;
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; starts one edge late so back-to-back calls never clash
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // waits as long as the answer takes; only the watchdog below ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), exp, rd_data);
  endtask : rd

  task key(input logic [7:0] b2);
    wr(`OFS_CLEAR, {24'h0, `KEY_FIRST});
    wr(`OFS_CLEAR, {24'h0, b2});
  endtask : key

  // count strobes, spaced so each one settles before the next
  task ticks(input logic ls, input int n);
    repeat (n) begin
      @(posedge pclk);
      rc_tick <= !ls;
      ls_tick <= ls;
      @(posedge pclk);
      rc_tick <= 1'b0;
      ls_tick <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : ticks

  task rst;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  // ----------------
  // tests
  // ----------------
  initial begin
    rst();
    for (int a = 1; a < 6; a++) rd(12'(4 * a), 32'h0);
    rd(12'h018, 32'h0);
    chk("slverr", 32'h1, err);
    wr(`OFS_EVT_MASK, 32'h7);
    rd(`OFS_EVT_MASK, 32'h7);
    ticks(1'b1, 2);
    rd(`OFS_COUNT, 32'h0);
    ticks(1'b0, 2);
    rd(`OFS_COUNT, 32'h2);
    rd(`OFS_STATUS, 32'h0);
    stop_mode <= 1'b1;
    ticks(1'b0, 3);
    rd(`OFS_COUNT, 32'h2);
    stop_mode <= 1'b0;
    wr(`OFS_MODE, 32'h10);
    ticks(1'b0, 2);
    ticks(1'b1, 1);
    rd(`OFS_COUNT, 32'h3);
    wr(`OFS_MODE, 32'h0);
    for (int l = 2; l < 4; l++) begin
      cpu_level <= 2'(l);
      key(`KEY_SECOND);
      rd(`OFS_STATUS, 32'h0);
      rd(`OFS_EVT_STATUS, 32'h4);
      chk("irq", 32'h1, irq);
      wr(`OFS_EVT_STATUS, 32'h4);
      rd(`OFS_COUNT, 32'h3);
    end
    chk("irq", 32'h0, irq);
    cpu_level <= 2'h1;
    key(8'h00);
    wr(`OFS_CLEAR, {24'h0, `KEY_SECOND});
    rd(`OFS_STATUS, 32'h0);
    key(`KEY_SECOND);
    rd(`OFS_STATUS, 32'h1);
    ticks(1'b0, 1);
    rd(`OFS_COUNT, 32'h0);
    rd(`OFS_STATUS, 32'h2);
    rd(`OFS_EVT_STATUS, 32'h2);
    ticks(1'b0, 1);
    rd(`OFS_STATUS, 32'h0);
    wr(`OFS_MODE, 32'h10);
    rd(`OFS_MODE, 32'h10);
    rst();
    wr(`OFS_EVT_MASK, 32'h7);
    ticks(1'b0, 7);
    rd(`OFS_EVT_STATUS, 32'h0);
    ticks(1'b0, 1);
    rd(`OFS_EVT_STATUS, 32'h1);
    rd(`OFS_STATUS, 32'h4);
    chk("irq", 32'h1, irq);
    wr(`OFS_EVT_STATUS, 32'h1);
    ticks(1'b0, 7);
    chk("reset", 32'h0, wdt_reset);
    ticks(1'b0, 1);
    chk("reset", 32'h1, wdt_reset);
    chk("invalid", 32'h0, invalid_clear);
    // both windows with a clear while the window is still shut
    for (int w = 1; w < 3; w++) begin
      rst();
      cpu_level <= 2'h0;
      wr(`OFS_MODE, 32'(w << 2));
      ticks(1'b0, 1);
      key(`KEY_SECOND);
      repeat (3) @(posedge pclk);
      chk("reset", 32'h1, wdt_reset);
      chk("invalid", 32'h1, invalid_clear);
    end
    rst();
    // only the overflow event may raise irq here; the clear event stays masked
    wr(`OFS_EVT_MASK, 32'h1);
    wr(`OFS_MODE, 32'h4);
    ticks(1'b0, 3);
    key(`KEY_SECOND);
    ticks(1'b0, 8);
    chk("reset", 32'h0, wdt_reset);
    ticks(1'b0, 1);
    chk("reset", 32'h1, wdt_reset);
    chk("irq", 32'h0, irq);
    chk("invalid", 32'h0, invalid_clear);
    rd(`OFS_EVT_STATUS, 32'h2);
    stop_test();
  end

  // cuts a hang short; the full run needs under 3000 cycles
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule : windowed_watchdog_timer_tb
